// [common/scs_defs.svh]
// register offsets, field positions, codes and reset values of the clock select block
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH
`define SCS_ADDR_W        12
`define SCS_OFS_STATUS    12'h00c
`define SCS_OFS_SELECT    12'h010
`define SCS_OFS_UNLOCK    12'h100
`define SCS_SYS_LSB       0
`define SCS_SYS_MSB       2
`define SCS_TICK_LSB      3
`define SCS_TICK_MSB      5
`define SCS_MISMATCH_BIT  7
`define SCS_STB_XTAL_BIT  0
`define SCS_STB_PLL_BIT   2
`define SCS_STB_SLOW_BIT  3
`define SCS_STB_FAST_BIT  4
`define SCS_SRC_XTAL      3'h0
`define SCS_SRC_PLL       3'h2
`define SCS_SRC_SLOW      3'h3
`define SCS_SRC_FAST      3'h7
`define SCS_TICK_XTAL     3'h0
`define SCS_TICK_XTAL_D2  3'h2
`define SCS_TICK_HCLK_D2  3'h3
`define SCS_TICK_FAST_D2  3'h7
`define SCS_TICK_RESET    3'h7
`define SCS_SYS_RESET     3'h7
`define SCS_KEY1          8'h59
`define SCS_KEY2          8'h16
`define SCS_KEY3          8'h88
`endif

// [common/scs_pkg.sv]
// types shared by the clock select block
`default_nettype none
`include "scs_defs.svh"
package scs_pkg;
  typedef struct packed {
    logic [`SCS_ADDR_W-1:0] addr;
    logic [31:0]            wdata;
    logic                   wr;
    logic                   rd;
  } scs_bus_req_t;
  typedef enum logic [3:0] {
    SCS_LOCKED = 4'b0001,
    SCS_KEY1_OK = 4'b0010,
    SCS_KEY2_OK = 4'b0100,
    SCS_OPEN    = 4'b1000
  } scs_lock_t;
endpackage
`default_nettype wire

// [rtl/scs_top.sv]
// system clock and tick clock source select with write protection
// Summary of operation
// - the active system clock source code follows the select field: 000 crystal, 010 pll, 011 slow rc, 111 fast rc.
// - after any reset the system select field is reloaded from the boot clock option pins.
// - both select fields are written only after the unlock bytes 59h, 16h, 88h have been written in order.
// - when the tick core clock choice is 1 the tick runs on every clock, otherwise it follows the tick select.
// - tick select decodes 000 crystal, 010 crystal/2, 011 clock/2, 111 fast rc/2, others give no tick.
// - the old source stays active until the new one is stable, and status bit 7 shows the mismatch meanwhile.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "scs_defs.svh"
module scs_top (
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire scs_pkg::scs_bus_req_t bus,
  output logic [31:0]               rd_data,
  input  wire logic [2:0]           boot_clock_option,
  input  wire logic                 tick_core_clock_choice,
  input  wire logic                 xtal_stable_pin,
  input  wire logic                 pll_stable_pin,
  input  wire logic                 slow_rc_stable_pin,
  input  wire logic                 fast_rc_stable_pin,
  input  wire logic                 external_crystal_clock,
  input  wire logic                 fast_internal_rc,
  output logic [2:0]                sys_clock_source,
  output logic                      switch_mismatch_flag,
  output logic                      tick_enable
);
  import scs_pkg::*;

  // two-flop synchronisers for every pin from another domain
  localparam int NSYNC = 6;
  wire logic [NSYNC-1:0] pin_in;
  wire logic [NSYNC-1:0] pin_sync;
  assign pin_in = {fast_internal_rc, external_crystal_clock, fast_rc_stable_pin,
                   slow_rc_stable_pin, pll_stable_pin, xtal_stable_pin};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      // per-bit flops keep one writer per variable
      logic stage1_reg;
      logic stage2_reg;
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          stage1_reg <= 1'b0;
          stage2_reg <= 1'b0;
        end else begin
          stage1_reg <= pin_in[gi];
          stage2_reg <= stage1_reg;
        end
      end
      assign pin_sync[gi] = stage2_reg;
    end
  endgenerate

  wire logic xtal_stb = pin_sync[0];
  wire logic pll_stb  = pin_sync[1];
  wire logic lrc_stb  = pin_sync[2];
  wire logic frc_stb  = pin_sync[3];
  wire logic xtal_lvl = pin_sync[4];
  wire logic frc_lvl  = pin_sync[5];

  // unlock sequence
  scs_lock_t lock_reg;
  scs_lock_t lock_next;
  wire logic [7:0] wbyte     = bus.wdata[7:0];
  wire logic       wr_unlock = bus.wr && (bus.addr == `SCS_OFS_UNLOCK);
  wire logic       wr_select = bus.wr && (bus.addr == `SCS_OFS_SELECT);
  wire logic       unlocked  = (lock_reg == SCS_OPEN);

  always_comb begin
    lock_next = lock_reg;
    if (wr_unlock) begin
      if (wbyte == `SCS_KEY1) begin
        lock_next = SCS_KEY1_OK;
      end else begin
        case (lock_reg)
          SCS_KEY1_OK: lock_next = (wbyte == `SCS_KEY2) ? SCS_KEY2_OK : SCS_LOCKED;
          SCS_KEY2_OK: lock_next = (wbyte == `SCS_KEY3) ? SCS_OPEN : SCS_LOCKED;
          default:     lock_next = SCS_LOCKED;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_reg <= SCS_LOCKED;
    end else begin
      lock_reg <= lock_next;
    end
  end

  // select register; the boot option is caught on the first edge after release
  logic       loaded_reg;
  logic [2:0] sys_sel_reg;
  logic [2:0] sys_sel_next;
  logic [2:0] tick_sel_reg;
  logic [2:0] tick_sel_next;
  logic [2:0] active_reg;
  logic [2:0] active_next;
  wire logic  sel_write = wr_select && unlocked;

  assign sys_sel_next  = !loaded_reg ? boot_clock_option :
                         sel_write ? bus.wdata[`SCS_SYS_MSB:`SCS_SYS_LSB] : sys_sel_reg;
  assign tick_sel_next = sel_write ? bus.wdata[`SCS_TICK_MSB:`SCS_TICK_LSB] : tick_sel_reg;

  // reserved code 001 has no stable source, so the old clock stays
  logic req_stable;
  always_comb begin
    case (sys_sel_reg)
      `SCS_SRC_XTAL: req_stable = xtal_stb;
      `SCS_SRC_PLL:  req_stable = pll_stb;
      `SCS_SRC_SLOW: req_stable = lrc_stb;
      `SCS_SRC_FAST: req_stable = frc_stb;
      default:       req_stable = 1'b0;
    endcase
  end

  assign active_next = !loaded_reg ? boot_clock_option :
                       req_stable ? sys_sel_reg : active_reg;
  wire logic mismatch_next = loaded_reg && (active_next != sys_sel_next);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      loaded_reg           <= 1'b0;
      sys_sel_reg          <= `SCS_SYS_RESET;
      tick_sel_reg         <= `SCS_TICK_RESET;
      active_reg           <= `SCS_SYS_RESET;
      switch_mismatch_flag <= 1'b0;
    end else begin
      loaded_reg           <= 1'b1;
      sys_sel_reg          <= sys_sel_next;
      tick_sel_reg         <= tick_sel_next;
      active_reg           <= active_next;
      switch_mismatch_flag <= mismatch_next;
    end
  end
  assign sys_clock_source = active_reg;

  // tick source: rising edges of sampled clocks, halved by toggles
  logic xtal_prev_reg;
  logic frc_prev_reg;
  logic xtal_half_reg;
  logic frc_half_reg;
  logic hclk_half_reg;
  wire logic xtal_rise = xtal_lvl && !xtal_prev_reg;
  wire logic frc_rise  = frc_lvl && !frc_prev_reg;
  logic tick_sel_pulse;
  always_comb begin
    case (tick_sel_reg)
      `SCS_TICK_XTAL:    tick_sel_pulse = xtal_rise;
      `SCS_TICK_XTAL_D2: tick_sel_pulse = xtal_rise && xtal_half_reg;
      `SCS_TICK_HCLK_D2: tick_sel_pulse = hclk_half_reg;
      `SCS_TICK_FAST_D2: tick_sel_pulse = frc_rise && frc_half_reg;
      default:           tick_sel_pulse = 1'b0;
    endcase
  end
  wire logic tick_next = tick_core_clock_choice | tick_sel_pulse;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      xtal_prev_reg <= 1'b0;
      frc_prev_reg  <= 1'b0;
      xtal_half_reg <= 1'b0;
      frc_half_reg  <= 1'b0;
      hclk_half_reg <= 1'b0;
      tick_enable   <= 1'b0;
    end else begin
      xtal_prev_reg <= xtal_lvl;
      frc_prev_reg  <= frc_lvl;
      xtal_half_reg <= xtal_half_reg ^ xtal_rise;
      frc_half_reg  <= frc_half_reg ^ frc_rise;
      hclk_half_reg <= ~hclk_half_reg;
      tick_enable   <= tick_next;
    end
  end

  // read mux; unmapped addresses read zero
  wire logic [31:0] status_word = {24'h0, switch_mismatch_flag, 2'h0, frc_stb, lrc_stb, pll_stb, 1'b0, xtal_stb};
  wire logic [31:0] select_word = {26'h0, tick_sel_reg, sys_sel_reg};
  wire logic [31:0] unlock_word = {31'h0, unlocked};
  wire logic [31:0] rd_mux = (bus.addr == `SCS_OFS_STATUS) ? status_word :
                             (bus.addr == `SCS_OFS_SELECT) ? select_word :
                             (bus.addr == `SCS_OFS_UNLOCK) ? unlock_word : 32'h00000000;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= 32'h00000000;
    end else begin
      rd_data <= bus.rd ? rd_mux : 32'h00000000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  locked_write_a: assert property (loaded_reg && wr_select && !unlocked |=> $stable(select_word))
    else $error("select changed while locked");
  open_write_a: assert property (loaded_reg && wr_select && unlocked |=> select_word[5:0] == $past(bus.wdata[5:0]))
    else $error("unlocked write not stored");
  unlock_seq_a: assert property (wr_unlock && wbyte == `SCS_KEY1 ##1 wr_unlock && wbyte == `SCS_KEY2
                                 ##1 wr_unlock && wbyte == `SCS_KEY3 |=> unlocked)
    else $error("unlock sequence failed");
  boot_load_a: assert property ($rose(loaded_reg) |-> sys_sel_reg == $past(boot_clock_option))
    else $error("boot option not loaded");
  hold_old_a: assert property (loaded_reg && !req_stable |=> active_reg == $past(active_reg))
    else $error("switched before source stable");
  mismatch_flag_a: assert property (loaded_reg ##1 loaded_reg |-> switch_mismatch_flag == (active_reg != sys_sel_reg))
    else $error("mismatch flag wrong");
  tick_hclk_a: assert property (tick_core_clock_choice |=> tick_enable)
    else $error("tick missing with core clock");
  tick_half_a: assert property (!tick_core_clock_choice && tick_sel_reg == `SCS_TICK_HCLK_D2 ##1
                                !tick_core_clock_choice && tick_sel_reg == `SCS_TICK_HCLK_D2
                                |=> tick_enable != $past(tick_enable))
    else $error("half clock tick wrong");
  tick_reserved_a: assert property (!tick_core_clock_choice && tick_sel_reg == 3'h1 |=> !tick_enable)
    else $error("reserved tick code ticked");
  upper_zero_a: assert property (bus.rd && bus.addr == `SCS_OFS_SELECT |=> rd_data[31:6] == 26'h0)
    else $error("reserved bits nonzero");
  sys_code_a: assert property (loaded_reg && sys_sel_reg == `SCS_SRC_PLL && pll_stb |=> sys_clock_source == `SCS_SRC_PLL)
    else $error("pll not selected");

  unlock_cover: cover property (unlocked && sel_write);
  switch_cover: cover property (switch_mismatch_flag ##1 !switch_mismatch_flag);
  tick_cover: cover property (!tick_core_clock_choice && tick_sel_reg == `SCS_TICK_XTAL_D2 && tick_enable);
endmodule // scs_top
`default_nettype wire

// [tb/scs_top_tb.sv]
// self-checking bench for the system and tick clock select block
`timescale 1ns/10ps
`default_nettype none
`include "scs_defs.svh"
module scs_top_tb;
  import scs_pkg::*;
  logic         clk;
  logic         arst_n;
  scs_bus_req_t bus;
  logic [31:0]  rd_data;
  logic [2:0]   boot_opt;
  logic         choice;
  logic [3:0]   stb;
  logic         xclk;
  logic         hrc;
  logic [2:0]   src;
  logic         mism;
  logic         tick;
  int           error_cnt;
  int           samples_checked;
  int           n;
  logic [2:0]   codes [4] = '{3'h0, 3'h2, 3'h3, 3'h7};
  logic [2:0]   tcode [5] = '{3'h0, 3'h2, 3'h3, 3'h7, 3'h1};
  int           tlo [5]   = '{11, 5, 59, 9, 0};
  int           thi [5]   = '{13, 7, 61, 11, 0};

  scs_top dut (.clk(clk), .arst_n(arst_n), .bus(bus), .rd_data(rd_data), .boot_clock_option(boot_opt),
    .tick_core_clock_choice(choice), .xtal_stable_pin(stb[0]), .pll_stable_pin(stb[1]),
    .slow_rc_stable_pin(stb[2]), .fast_rc_stable_pin(stb[3]), .external_crystal_clock(xclk),
    .fast_internal_rc(hrc), .sys_clock_source(src), .switch_mismatch_flag(mism), .tick_enable(tick));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // both tick sources stay well under half the core clock
  initial begin
    xclk = 1'b0;
    forever #40 xclk = ~xclk;
  end
  initial begin
    hrc = 1'b0;
    forever #24 hrc = ~hrc;
  end

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  // read data is looked at only in the cycle after the strobe
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask

  // back-to-back key writes, one per cycle, so the unlock assertion is exercised
  task automatic unlock();
    @(posedge clk);
    bus <= '{addr: `SCS_OFS_UNLOCK, wdata: 32'h59, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wdata <= 32'h16;
    @(posedge clk);
    bus.wdata <= 32'h88;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic wait_src(input logic [2:0] exp);
    n = 0;
    #1;
    while (src !== exp && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({29'h0, src}, {29'h0, exp});
    if (src !== exp)
      conclude();
  endtask

  task automatic count_ticks(input int cycles, input int lo, input int hi);
    n = 0;
    repeat (cycles) begin
      @(posedge clk);
      #1;
      if (tick === 1'b1)
        n++;
    end
    chk({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask

  initial begin
    arst_n = 1'b0;
    bus = '0;
    boot_opt = 3'h0;
    choice = 1'b0;
    stb = 4'hf;
    error_cnt = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({29'h0, src}, 32'h0);
    rdc(`SCS_OFS_SELECT, 32'h38);
    wr(`SCS_OFS_SELECT, 32'h12);
    rdc(`SCS_OFS_SELECT, 32'h38);
    wr(`SCS_OFS_UNLOCK, 32'h59);
    wr(`SCS_OFS_UNLOCK, 32'h16);
    wr(`SCS_OFS_UNLOCK, 32'h00);
    wr(`SCS_OFS_UNLOCK, 32'h88);
    rdc(`SCS_OFS_UNLOCK, 32'h0);
    rdc(12'h020, 32'h0);
    $display("test boot and lock done");
    unlock();
    rdc(`SCS_OFS_UNLOCK, 32'h1);
    stb <= 4'b1101;
    wr(`SCS_OFS_SELECT, 32'hffff_ffd2);
    rdc(`SCS_OFS_SELECT, 32'h12);
    repeat (4) @(posedge clk);
    #1;
    chk({29'h0, src}, 32'h0);
    rdc(`SCS_OFS_STATUS, 32'h99);
    stb <= 4'hf;
    wait_src(3'h2);
    chk({31'h0, mism}, 32'h0);
    foreach (codes[i]) begin
      wr(`SCS_OFS_SELECT, {26'h0, 3'h3, codes[i]});
      wait_src(codes[i]);
    end
    wr(`SCS_OFS_SELECT, 32'h19);
    repeat (10) @(posedge clk);
    #1;
    chk({28'h0, mism, src}, 32'hf);
    $display("test switching done");
    choice <= 1'b1;
    repeat (2) @(posedge clk);
    count_ticks(20, 20, 20);
    choice <= 1'b0;
    foreach (tcode[i]) begin
      wr(`SCS_OFS_SELECT, {26'h0, tcode[i], 3'h7});
      repeat (6) @(posedge clk);
      count_ticks(120, tlo[i], thi[i]);
    end
    wr(`SCS_OFS_UNLOCK, 32'h0);
    wr(`SCS_OFS_SELECT, 32'h07);
    rdc(`SCS_OFS_SELECT, 32'h0f);
    $display("test tick done");
    boot_opt <= 3'h7;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({29'h0, src}, 32'h7);
    wr(`SCS_OFS_SELECT, 32'h00);
    rdc(`SCS_OFS_SELECT, 32'h3f);
    $display("test second reset done");
    conclude();
  end
endmodule // scs_top_tb
`default_nettype wire
